// file: rtl/eepc_top.sv
// Purpose: 4096-byte nonvolatile array with program, erase and block protect
// Assumes: APB slave on clock; wait, stop and size come from same-clock logic
// Notes: special_mode_n is a pin and is synchronised
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "eepc_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 4096-byte array, read as bytes, aligned words or misaligned words.
// - byte and aligned word reads take one cycle, misaligned two.
// - programming works on one byte or one aligned word only.
// - misaligned program or erase latches only its upper byte.
// - erase one byte, aligned word, 32-byte row or whole array.
// - odd-row or even-row bulk erase only in test modes.
// - program and erase allowed in every operating mode.
// - control block at 0x00F0, map register at 0x0010, array from 0x1000 to 0x1FFF.
// - access enable gates bus array access, not registers or programming.
// - program or erase keeps running in wait mode while the wait-stop bit is clear.
// - stop removes voltage and rc clock, keeps apply bit, then resumes.
// - wait-stop bit freezes the module in wait mode when set.
// - lock bit freezes protect bits; write once normal, free special.
// - pump clock select picks rc oscillator when 1, writable anytime.
// - block protect writable only with apply bit and lock both clear.
// - a set protect bit blocks program and erase of its block.
// - seven blocks 2048,1024,512,256,128,64,64 bytes up to the top.
// - apply bit sets only if latch bit already set.
// - bulk erase protect writable only unlocked and idle; blocks bulk/row.
module eepc_top #(
    parameter int unsigned PE_CYCLES = `EEPC_PE_CYCLES
) (
    input wire logic clock, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [15:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    input wire logic word_access, // 16-bit access when high
    input wire logic wait_mode, // core in wait mode
    input wire logic stop_mode, // core in stop mode
    input wire logic special_mode_n, // mode pin, low in special modes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output eepc_pkg::eepc_pump_t pump_status // charge pump controls
);

    logic [7:0] mem [0:4095];
    logic [7:0] cfg_reg;
    logic [7:0] prot_reg;
    logic [7:0] test_reg;
    logic [7:0] prog_reg;
    logic [7:0] init_reg;
    logic lock_once_reg;
    logic smod_meta_reg;
    logic smod_reg;
    eepc_pkg::eepc_state_t state_reg;
    eepc_pkg::eepc_latch_t lat_reg;
    logic [7:0] mis_byte_reg;
    logic [17:0] pe_cnt_reg;
    logic pe_done_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    eepc_pkg::eepc_pump_t pump_reg;

    logic run;
    logic special;
    logic setup;
    logic acc_done;
    logic wr_done;
    logic is_arr;
    logic [11:0] aoff;
    logic [11:0] anext;
    logic mis;
    logic reg_hit;
    logic arr_ok;
    logic [31:0] rd_data;
    logic [7:0] test_eff;
    logic pgm;
    logic lat;
    logic volt;
    logic fire;

    //////////////////////////////////////////////////////////////////////////
    // global gating
    assign run = ce & ~(wait_mode & cfg_reg[`EEPC_CFG_SWAI]);
    assign special = ~smod_reg;
    // test bits read and act as zero outside special modes
    assign test_eff = test_reg & {8{special}};
    assign pgm = prog_reg[`EEPC_PRG_PGM];
    assign lat = prog_reg[`EEPC_PRG_LAT];

    // mode pin synchroniser
    always_ff @(posedge clock) begin
        if (!nrst) begin
            smod_meta_reg <= 1'b1;
            smod_reg <= 1'b1;
        end else if (ce) begin
            smod_meta_reg <= special_mode_n;
            smod_reg <= smod_meta_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // address decode
    assign setup = psel & ~penable;
    assign acc_done = psel & penable & pready_reg;
    assign wr_done = acc_done & pwrite;
    assign is_arr = (paddr[15:12] == `EEPC_ARR_PAGE);
    assign aoff = paddr[11:0];
    assign anext = aoff + 12'h001;
    assign mis = word_access & aoff[0];
    assign reg_hit = (paddr == `EEPC_OFF_CFG) | (paddr == `EEPC_OFF_PROT) |
                     (paddr == `EEPC_OFF_TEST) | (paddr == `EEPC_OFF_PROG) |
                     (paddr == `EEPC_OFF_INIT);
    // latch writes for programming pass even with bus access disabled
    assign arr_ok = is_arr & (init_reg[`EEPC_INIT_EN] | (pwrite & lat));

    // read mux; the array reads zero while the latches hold it
    always_comb begin
        rd_data = 32'h0000_0000;
        if (is_arr) begin
            if (lat) begin
                rd_data = 32'h0000_0000;
            end else if (word_access) begin
                rd_data = {16'h0000, mem[aoff], mem[anext]};
            end else begin
                rd_data = {24'h00_0000, mem[aoff]};
            end
        end else begin
            case (paddr)
                `EEPC_OFF_CFG: rd_data = {24'h00_0000, cfg_reg};
                `EEPC_OFF_PROT: rd_data = {24'h00_0000, prot_reg};
                `EEPC_OFF_TEST: rd_data = {24'h00_0000, test_eff};
                `EEPC_OFF_PROG: rd_data = {24'h00_0000, prog_reg};
                `EEPC_OFF_INIT: rd_data = {24'h00_0000, init_reg};
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // bus answer sequencer, ready is registered so it rises in the access phase
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= eepc_pkg::EEPC_IDLE;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            mis_byte_reg <= 8'h00;
        end else if (run) begin
            case (state_reg)
                eepc_pkg::EEPC_IDLE: begin
                    if (setup) begin
                        if (!pwrite && arr_ok && mis && !lat) begin
                            mis_byte_reg <= mem[aoff];
                            state_reg <= eepc_pkg::EEPC_MISAL;
                        end else begin
                            prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
                            pslverr_reg <= ~(reg_hit | arr_ok);
                            pready_reg <= 1'b1;
                            state_reg <= eepc_pkg::EEPC_RESP;
                        end
                    end
                end
                eepc_pkg::EEPC_MISAL: begin
                    // second byte fetched a cycle later
                    prdata_reg <= {16'h0000, mis_byte_reg, mem[anext]};
                    pslverr_reg <= 1'b0;
                    pready_reg <= 1'b1;
                    state_reg <= eepc_pkg::EEPC_RESP;
                end
                eepc_pkg::EEPC_RESP: begin
                    if (acc_done) begin
                        pready_reg <= 1'b0;
                        pslverr_reg <= 1'b0;
                        state_reg <= eepc_pkg::EEPC_IDLE;
                    end
                end
                default: begin
                    pready_reg <= 1'b0;
                    state_reg <= eepc_pkg::EEPC_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // module config register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfg_reg <= `EEPC_CFG_RST;
            lock_once_reg <= 1'b0;
        end else if (run && wr_done && pstrb[0] && paddr == `EEPC_OFF_CFG) begin
            cfg_reg[`EEPC_CFG_SWAI] <= pwdata[`EEPC_CFG_SWAI];
            cfg_reg[`EEPC_CFG_RC] <= pwdata[`EEPC_CFG_RC];
            if (special || !lock_once_reg) begin
                cfg_reg[`EEPC_CFG_LOCK] <= pwdata[`EEPC_CFG_LOCK];
            end
            // first write in normal mode uses up the single chance
            lock_once_reg <= lock_once_reg | ~special;
        end
    end

    // block protect register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prot_reg <= `EEPC_PROT_RST;
        end else if (run && wr_done && pstrb[0] && paddr == `EEPC_OFF_PROT) begin
            if (!pgm && !cfg_reg[`EEPC_CFG_LOCK]) begin
                prot_reg <= {1'b0, pwdata[6:0]};
            end
        end
    end

    // test register, special modes only
    always_ff @(posedge clock) begin
        if (!nrst) begin
            test_reg <= `EEPC_TEST_RST;
        end else if (run && wr_done && pstrb[0] && paddr == `EEPC_OFF_TEST && special) begin
            test_reg <= {6'h00, pwdata[`EEPC_TST_EVEN], pwdata[`EEPC_TST_ODD]};
        end
    end

    // program control register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prog_reg <= `EEPC_PROG_RST;
        end else if (run && wr_done && pstrb[0] && paddr == `EEPC_OFF_PROG) begin
            if (pgm) begin
                // setup bits frozen while voltage is applied
                prog_reg[`EEPC_PRG_PGM] <= pwdata[`EEPC_PRG_PGM];
            end else begin
                prog_reg[`EEPC_PRG_LAT] <= pwdata[`EEPC_PRG_LAT];
                prog_reg[`EEPC_PRG_ERASE] <= pwdata[`EEPC_PRG_ERASE];
                prog_reg[`EEPC_PRG_ROW] <= pwdata[`EEPC_PRG_ROW];
                prog_reg[`EEPC_PRG_BYTE] <= pwdata[`EEPC_PRG_BYTE];
                // old latch value: writing both at once leaves apply clear
                prog_reg[`EEPC_PRG_PGM] <= pwdata[`EEPC_PRG_PGM] & lat;
                if (!cfg_reg[`EEPC_CFG_LOCK]) begin
                    prog_reg[`EEPC_PRG_BULK_ERASE_PROTECT] <= pwdata[`EEPC_PRG_BULK_ERASE_PROTECT];
                end
            end
        end
    end

    // array map register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            init_reg <= `EEPC_INIT_RST;
        end else if (run && wr_done && pstrb[0] && paddr == `EEPC_OFF_INIT) begin
            init_reg <= {7'h00, pwdata[`EEPC_INIT_EN]};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // programming latches; frozen while voltage is applied
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lat_reg <= '0;
        end else if (run) begin
            if (!lat) begin
                lat_reg.valid <= 1'b0;
            end else if (wr_done && is_arr && !pgm) begin
                lat_reg.addr <= aoff;
                lat_reg.valid <= 1'b1;
                if (word_access && !mis) begin
                    lat_reg.word <= 1'b1;
                    lat_reg.data <= pwdata[15:0];
                end else if (mis) begin
                    // only the byte at the given address survives
                    lat_reg.word <= 1'b0;
                    lat_reg.data <= {8'h00, pwdata[15:8]};
                end else begin
                    lat_reg.word <= 1'b0;
                    lat_reg.data <= {8'h00, pwdata[7:0]};
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // program/erase timer; stop holds it so the pulse resumes afterwards
    assign volt = pgm & ~stop_mode;
    assign fire = volt & ~pe_done_reg & lat_reg.valid & (pe_cnt_reg == 18'(PE_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pe_cnt_reg <= 18'h0_0000;
            pe_done_reg <= 1'b0;
        end else if (run) begin
            if (!pgm) begin
                pe_cnt_reg <= 18'h0_0000;
                pe_done_reg <= 1'b0;
            end else if (volt && !pe_done_reg) begin
                if (pe_cnt_reg == 18'(PE_CYCLES - 1)) begin
                    pe_done_reg <= 1'b1;
                end else begin
                    pe_cnt_reg <= pe_cnt_reg + 18'h0_0001;
                end
            end
        end
    end

    // protect bit covering one byte address, smallest blocks at the top
    function automatic logic blk_prot(input logic [11:0] a, input logic [7:0] p);
        logic r;
        r = p[0];
        if (!a[11]) r = p[6];
        else if (!a[10]) r = p[5];
        else if (!a[9]) r = p[4];
        else if (!a[8]) r = p[3];
        else if (!a[7]) r = p[2];
        else if (!a[6]) r = p[1];
        return r;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // array update at the end of the pulse; programming only clears bits
    always_ff @(posedge clock) begin
        logic [11:0] ia;
        logic [11:0] a0;
        logic [11:0] a1;
        logic sel;
        ia = 12'h000;
        a0 = lat_reg.word ? {lat_reg.addr[11:1], 1'b0} : lat_reg.addr;
        a1 = {lat_reg.addr[11:1], 1'b1};
        sel = 1'b0;
        if (run && fire) begin
            if (prog_reg[`EEPC_PRG_ERASE] && !prog_reg[`EEPC_PRG_BYTE]) begin
                for (int i = 0; i < 4096; i++) begin
                    ia = 12'(i);
                    if (prog_reg[`EEPC_PRG_ROW]) begin
                        sel = (ia[11:5] == lat_reg.addr[11:5]);
                    end else if (test_eff[1:0] != 2'b00) begin
                        sel = ia[5] ? test_eff[`EEPC_TST_ODD] : test_eff[`EEPC_TST_EVEN];
                    end else begin
                        sel = 1'b1;
                    end
                    if (sel && !prog_reg[`EEPC_PRG_BULK_ERASE_PROTECT] && !blk_prot(ia, prot_reg)) begin
                        mem[i] <= `EEPC_ERASED;
                    end
                end
            end else if (prog_reg[`EEPC_PRG_ERASE]) begin
                if (!blk_prot(a0, prot_reg)) begin
                    mem[a0] <= `EEPC_ERASED;
                end
                if (lat_reg.word && !blk_prot(a1, prot_reg)) begin
                    mem[a1] <= `EEPC_ERASED;
                end
            end else if (lat_reg.word) begin
                if (!blk_prot(a0, prot_reg)) begin
                    mem[a0] <= mem[a0] & lat_reg.data[15:8];
                end
                if (!blk_prot(a1, prot_reg)) begin
                    mem[a1] <= mem[a1] & lat_reg.data[7:0];
                end
            end else if (!blk_prot(a0, prot_reg)) begin
                mem[a0] <= mem[a0] & lat_reg.data[7:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pump controls; apply bit stays set through stop
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pump_reg <= '0;
        end else if (run) begin
            pump_reg.volt_on <= volt & ~pe_done_reg;
            pump_reg.rc_run <= cfg_reg[`EEPC_CFG_RC] & ~stop_mode;
            pump_reg.rc_sel <= cfg_reg[`EEPC_CFG_RC];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pump_status = pump_reg;

endmodule // eepc_top

// file: rtl/eepc_regs.svh
// Purpose: offsets, bit positions, reset values and timing counts
// Assumes: byte addresses on a 16-bit APB address
// Notes: definitions only
`ifndef EEPC_REGS_SVH
`define EEPC_REGS_SVH
// register and array addresses
`define EEPC_OFF_CFG 16'h00F0
`define EEPC_OFF_PROT 16'h00F4
`define EEPC_OFF_TEST 16'h00F8
`define EEPC_OFF_PROG 16'h00FC
`define EEPC_OFF_INIT 16'h0010
`define EEPC_ARR_PAGE 4'h1
// module config bits
`define EEPC_CFG_SWAI 0
`define EEPC_CFG_LOCK 1
`define EEPC_CFG_RC 2
// program control bits
`define EEPC_PRG_PGM 0
`define EEPC_PRG_LAT 1
`define EEPC_PRG_ERASE 2
`define EEPC_PRG_ROW 3
`define EEPC_PRG_BYTE 4
`define EEPC_PRG_BULK_ERASE_PROTECT 7
// test bits
`define EEPC_TST_ODD 0
`define EEPC_TST_EVEN 1
// array map bit
`define EEPC_INIT_EN 0
// reset values
`define EEPC_CFG_RST 8'h00
`define EEPC_PROT_RST 8'h7F
`define EEPC_TEST_RST 8'h00
`define EEPC_PROG_RST 8'h90
`define EEPC_INIT_RST 8'h01
`define EEPC_ERASED 8'hFF
// timing
`define EEPC_CLK_MHZ 25
`define EEPC_PE_TIME_US 10000
`define EEPC_PE_CYCLES (`EEPC_PE_TIME_US * `EEPC_CLK_MHZ)
`endif

// file: rtl/eepc_pkg.sv
// Purpose: types shared by the array controller
// Assumes: nothing
// Notes: constants live in eepc_regs.svh
package eepc_pkg;
    // bus answer sequencer
    typedef enum logic [2:0] {
        EEPC_IDLE = 3'b001,
        EEPC_MISAL = 3'b010,
        EEPC_RESP = 3'b100
    } eepc_state_t;
    // programming latches
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] data;
        logic word;
        logic valid;
    } eepc_latch_t;
    // charge pump status
    typedef struct packed {
        logic volt_on;
        logic rc_run;
        logic rc_sel;
    } eepc_pump_t;
endpackage

// file: test/eepc_cpu.sv
// Purpose: processor bus master facing the array controller
// Assumes: tasks start just after a rising edge
// Notes: bus idles one cycle after each transfer
module eepc_cpu (
    input wire logic clock, // system clock
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    output logic psel, // select
    output logic penable, // enable
    output logic pwrite, // direction
    output logic [15:0] paddr, // byte address
    output logic [31:0] pwdata, // write data
    output logic word_access // 16-bit access
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idle from time zero
    initial {psel, penable, pwrite, paddr, pwdata, word_access} = 52'h0;
    //////////////////////////////////////////////////////////////////////////
    // request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        word_access <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // stale data must not look valid
        @(posedge clock);
    endtask
endmodule // eepc_cpu

// file: test/eepc_top_sva.sv
// Purpose: port checker for the array controller
// Assumes: wait clock stop stays clear
// Notes: bound to eepc_top below
module eepc_chk (
    input wire logic clock, // system clock
    input wire logic nrst, // reset, active low
    input wire logic ce, // clock enable
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [15:0] paddr, // apb address
    input wire logic word_access, // 16-bit access
    input wire logic stop_mode, // stop mode
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire eepc_pkg::eepc_pump_t pump_status // pump controls
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic arr, unmap, setup, misal;
    // request decode
    assign arr = paddr[15:12] == 4'h1;
    assign unmap = !arr && !(paddr inside {16'h00F0, 16'h00F4, 16'h00F8, 16'h00FC, 16'h0010});
    assign setup = psel && !penable && ce;
    assign misal = arr && !pwrite && word_access && paddr[0];
    //////////////////////////////////////////////////////////////////////////
    a_ready_once: assert property (psel && penable && pready && ce |=> !pready)
        else $error("ready held too long");
    a_fast_access: assert property (setup && !misal |=> pready)
        else $error("no zero-wait answer");
    a_misal_wait: assert property (setup && misal |=> !pready ##1 pready)
        else $error("misaligned read timing");
    a_unmap_err: assert property (setup && unmap |=> pready && pslverr)
        else $error("unmapped not refused");
    a_answer_holds: assert property (pready && !(psel && penable) && ce |=> pready && $stable(prdata))
        else $error("answer dropped early");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_reg_upper: assert property (pready && !pwrite && !arr |-> prdata[31:8] == 24'h0)
        else $error("register upper bits set");
    a_stop_volt: assert property (stop_mode && ce |=> !pump_status.volt_on && !pump_status.rc_run)
        else $error("pump active in stop");
    a_rc_select: assert property (pump_status.rc_run |-> pump_status.rc_sel)
        else $error("rc runs unselected");
endmodule // eepc_chk
bind eepc_top eepc_chk u_chk (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .word_access(word_access), .stop_mode(stop_mode),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_status(pump_status));

// file: test/tb.sv
// Purpose: self-checking bench for the array controller
// Assumes: pulse length shortened to PE cycles
// Notes: full-rate bus clock, no rc pump clock needed
`include "eepc_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PE = 8;
    localparam logic [11:0] EA [4] = '{12'h0A5, 12'h3C4, 12'h7E0, 12'h7E0};
    localparam logic [7:0] EM [4] = '{8'h14, 8'h14, 8'h0C, 8'h8C};
    localparam logic [15:0] RA [5] = '{`EEPC_OFF_CFG, `EEPC_OFF_PROT, `EEPC_OFF_TEST, `EEPC_OFF_PROG, `EEPC_OFF_INIT};
    localparam logic [7:0] RV [5] = '{`EEPC_CFG_RST, `EEPC_PROT_RST, `EEPC_TEST_RST, `EEPC_PROG_RST, `EEPC_INIT_RST};
    logic clock, nrst, ce, wait_mode, stop_mode, special_mode_n;
    logic psel, penable, pwrite, word_access, pready, pslverr, errv;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [11:0] a;
    logic [7:0] mem [4096];
    eepc_pkg::eepc_pump_t pump_status;
    int fails = 0, samples_checked = 0, seed = 1;
    eepc_top #(.PE_CYCLES(PE)) dut (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .word_access(word_access),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .special_mode_n(special_mode_n), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pump_status(pump_status));
    eepc_cpu u_cpu (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .word_access(word_access));
    // 25 MHz needs no rc pump clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] ad, input logic [31:0] dt, input logic w = 1'b0);
        u_cpu.xfer(1'b1, ad, dt, w, rdv, errv);
    endtask
    task automatic rd(input logic [15:0] ad, output logic [31:0] v, input logic w = 1'b0);
        u_cpu.xfer(1'b0, ad, 32'h0, w, v, errv);
    endtask
    // protect bit index of a byte
    function automatic int blk(input logic [11:0] ad);
        for (int b = 11; b > 5; b--) if (!ad[b]) return b - 5;
        return 0;
    endfunction
    // latch, apply, wait, release; core sits in wait meanwhile
    task automatic pe_op(input logic [7:0] m, input logic [11:0] ad, input logic [15:0] dt, input logic w,
                         input logic stp);
        wr(`EEPC_OFF_PROG, {24'h0, m | 8'h02});
        wr(16'h1000 | 16'(ad), {16'h0, dt}, w);
        wr(`EEPC_OFF_PROG, {24'h0, m | 8'h03});
        if (stp) begin
            stop_mode <= 1'b1;
            repeat (PE + 4) @(posedge clock);
            check("volt_on", {31'h0, pump_status.volt_on}, 32'h0);
            stop_mode <= 1'b0;
            rd(`EEPC_OFF_PROG, rdv);
            check("prog in stop", rdv, {24'h0, m | 8'h03});
            wr(`EEPC_OFF_PROT, 32'h7F);
            rd(`EEPC_OFF_PROT, rdv);
            check("prot while apply", rdv, 32'h0);
        end
        wait_mode <= 1'b1;
        repeat (PE + 8) @(posedge clock);
        wait_mode <= 1'b0;
        wr(`EEPC_OFF_PROG, {24'h0, m | 8'h02});
        wr(`EEPC_OFF_PROG, {24'h0, m});
    endtask
    // program and mirror; misaligned keeps the upper byte
    task automatic prog(input logic [11:0] ad, input logic [15:0] dt, input logic w, input logic [6:0] p);
        pe_op(8'h10, ad, dt, w, 1'b0);
        if (!p[blk(ad)]) begin
            mem[ad] &= w ? dt[15:8] : dt[7:0];
            if (w && !ad[0]) mem[ad + 12'h1] &= dt[7:0];
        end
    endtask
    task automatic rchk(input logic [11:0] ad, input logic w);
        rd(16'h1000 | 16'(ad), rdv, w);
        check("array", rdv, w ? {16'h0, mem[ad], mem[ad + 12'h1]} : {24'h0, mem[ad]});
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        stop_test;
    end
    initial begin
        {ce, wait_mode, stop_mode, special_mode_n, nrst} = 5'h12;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        // reset values, refused accesses
        for (int i = 0; i < 5; i++) begin
            rd(RA[i], rdv);
            check("reset value", rdv, {24'h0, RV[i]});
        end
        rd(16'h2000, rdv);
        check("unmapped", {31'h0, errv}, 32'h1);
        wr(`EEPC_OFF_INIT, 32'h0);
        rd(16'h1000, rdv);
        check("disabled", {31'h0, errv}, 32'h1);
        wr(`EEPC_OFF_INIT, 32'h1);
        // bulk erase with a stop mid-pulse, before any program
        wr(`EEPC_OFF_PROT, 32'h0);
        pe_op(8'h04, 12'h000, 16'h0, 1'b0, 1'b1);
        foreach (mem[i]) mem[i] = 8'hFF;
        for (int i = 0; i < 24; i++) begin
            a = 12'($random(seed));
            if (a == 12'hFFF) a = 12'hFFE;
            prog(a, 16'($random(seed)), 1'($random(seed)), 7'h0);
            rchk(a, 1'b0);
            rchk(a, 1'b1);
        end
        // byte, word, row erase; row erase under bulk protect refused
        for (int k = 0; k < 4; k++) begin
            prog(EA[k], 16'h0, 1'b1, 7'h0);
            pe_op(EM[k], EA[k], 16'h0, k == 1, 1'b0);
            for (int j = 0; j < (k == 2 ? 32 : k == 1 ? 2 : k == 0 ? 1 : 0); j++)
                mem[EA[k] + j] = 8'hFF;
            rchk(EA[k], 1'b1);
            rchk(EA[k] + 12'd30, 1'b1);
        end
        // each protect bit: top byte of its block held, next byte free
        for (int k = 0; k < 7; k++) begin
            a = 12'hFFF - (k == 0 ? 12'h0 : 12'(32 << k));
            wr(`EEPC_OFF_PROT, 32'(1 << k));
            prog(a, 16'h0, 1'b0, 7'(1 << k));
            prog(a + 12'h1, 16'h0, 1'b0, 7'(1 << k));
            rchk(a, 1'b0);
            rchk(a + 12'h1, 1'b0);
        end
        wr(`EEPC_OFF_PROG, 32'h03);
        rd(`EEPC_OFF_PROG, rdv);
        check("prog", rdv, 32'h02);
        wr(`EEPC_OFF_PROG, 32'h0);
        // lock taken by the first normal write, pump select stays free
        wr(`EEPC_OFF_CFG, 32'h02);
        wr(`EEPC_OFF_PROT, 32'h7F);
        rd(`EEPC_OFF_PROT, rdv);
        check("locked prot", rdv, 32'h40);
        wr(`EEPC_OFF_CFG, 32'h04);
        rd(`EEPC_OFF_CFG, rdv);
        check("cfg", rdv, 32'h06);
        check("rc_run", {31'h0, pump_status.rc_run}, 32'h1);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clock);
        check("rc_run stop", {31'h0, pump_status.rc_run}, 32'h0);
        stop_mode <= 1'b0;
        wr(`EEPC_OFF_TEST, 32'h01);
        rd(`EEPC_OFF_TEST, rdv);
        check("test normal", rdv, 32'h0);
        // special mode: lock clears, test bits write
        special_mode_n <= 1'b0;
        repeat (3) @(posedge clock);
        wr(`EEPC_OFF_CFG, 32'h00);
        rd(`EEPC_OFF_CFG, rdv);
        check("cfg special", rdv, 32'h0);
        wr(`EEPC_OFF_TEST, 32'h01);
        rd(`EEPC_OFF_TEST, rdv);
        check("test special", rdv, 32'h1);
        stop_test;
    end
endmodule // tb
